// ---- common/csf_pkg.sv ----
// Package: constants and carrier types for the CPU stack and flags block
// Notes on behaviour
// - The result_null_flag (cc bit 1) is set when the last ALU result is zero, else cleared.
// - branch_if_equal and branch_if_not_equal decide by testing the result_null_flag.
// - The overflow_borrow_flag (cc bit 0) is set on arithmetic overflow or underflow, else cleared.
// - force_carry_instr sets and clear_carry_instr clears the carry; carry branches test it.
// - Bit-test-and-branch, shift and rotate operations also update the carry flag.
// - The stack pointer is 16 bits with the upper ten bits fixed (00h high, bits 7:6 one).
// - The pointer addresses the next free byte, decrements after push, increments before pop.
// - Reset or reload_stack_top_instr sets the pointer to 00FFh, the stack top.
// - The pointer low byte can be read and written directly by the load instruction.
// - A push below the lower limit wraps to the upper limit with no overflow indication.
// - A pop beyond the upper limit wraps to the lower limit with no indication.
// - Interrupt entry stores program_counter_low first, then the rest at decreasing addresses.
// - A call pushes two bytes of return address; an interrupt pushes five context bytes.
// - Interrupt context is the program counter, X, accumulator and condition codes.
// - The Y index register is never saved or restored by interrupt entry or return.
package csf_pkg;

	localparam logic [15:0] SP_RESET_VAL = 16'h00FF;
	localparam logic [9:0]  SP_FIXED_HI  = 10'h003;
	localparam int          SP_OFS_W     = 6;
	localparam int          CC_Z_BIT     = 1;
	localparam int          CC_C_BIT     = 0;
	localparam logic [2:0]  CTX_LAST     = 3'h4;
	localparam logic [2:0]  CALL_LAST    = 3'h1;

	// Flag update commands from the instruction decoder
	typedef enum logic [2:0] {
		CSF_FL_NONE,
		CSF_FL_ALU,
		CSF_FL_Z_ONLY,
		CSF_FL_SCF,
		CSF_FL_RCF
	} csf_flag_op_t;

	// Stack sequence commands
	typedef enum logic [2:0] {
		CSF_SK_NONE,
		CSF_SK_PUSH,
		CSF_SK_POP,
		CSF_SK_CALL,
		CSF_SK_RET,
		CSF_SK_INT,
		CSF_SK_IRET
	} csf_stack_op_t;

	typedef enum logic [1:0] {
		CSF_BR_EQ,
		CSF_BR_NE,
		CSF_BR_C,
		CSF_BR_NC
	} csf_branch_t;

	// Context bytes as presented by the core
	typedef struct packed {
		logic [7:0] program_counter_low;
		logic [7:0] pch;
		logic [7:0] x;
		logic [7:0] a;
		logic [7:0] cc;
	} csf_ctx_t;

	typedef struct packed {
		logic       we;
		logic [5:0] addr;
		logic [7:0] wdata;
	} csf_mem_req_t;

endpackage : csf_pkg

// ---- hw/csf_stack_ram.sv ----
// File: 64-byte stack memory with registered read data
`timescale 1ns/1ns
module csf_stack_ram
	import csf_pkg::*;
(
	// Clock
	input  wire logic         mclk,
	// Access
	input  wire csf_mem_req_t req,
	output logic [7:0]        rdata
);

	logic [7:0] mem [0:(1 << SP_OFS_W) - 1];

	always_ff @(posedge mclk) begin
		if (req.we) begin
			mem[req.addr] <= req.wdata;
		end
		rdata <= mem[req.addr];
	end

endmodule : csf_stack_ram

// ---- hw/csf_core.sv ----
// File: stack pointer, stack sequencer and zero/carry flags of the core
`timescale 1ns/1ns
module csf_core
	import csf_pkg::*;
(
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	// Flag update
	input  wire csf_flag_op_t  flag_op,
	input  wire logic [7:0]    alu_result,
	input  wire logic          alu_carry,
	// Branch test
	input  wire csf_branch_t   branch_sel,
	output logic               branch_taken,
	// Stack command
	input  wire csf_stack_op_t stack_op,
	input  wire logic [7:0]    push_data,
	input  wire csf_ctx_t      ctx_in,
	input  wire logic          reload_stack_top_instr,
	output logic               stack_busy,
	output logic               pop_valid,
	output logic [7:0]         pop_data,
	output logic [2:0]         pop_index,
	// Load instruction access to the pointer low byte
	input  wire logic          sp_low_we,
	input  wire logic [7:0]    sp_low_wdata,
	output logic [7:0]         pointer_low_byte,
	// State
	output logic [15:0]        stack_pointer,
	output logic               result_null_flag,
	output logic               overflow_borrow_flag
);

	typedef enum logic [1:0] {
		CSF_ST_IDLE,
		CSF_ST_PUSH,
		CSF_ST_POP
	} csf_state_t;

	typedef struct packed {
		csf_state_t      state;
		logic [5:0]      sp;
		logic [2:0]      idx;
		logic [2:0]      last;
		logic            z;
		logic            c;
		logic            rd_pend;
		logic [2:0]      rd_idx;
		logic            pv;
		logic [7:0]      pd;
		logic [2:0]      pi;
		logic [39:0]     ctx;
	} csf_regs_t;

	csf_regs_t    s_reg;
	csf_regs_t    s_next;
	csf_mem_req_t mreq;
	logic [7:0]   rdata;

	csf_stack_ram u_ram (
		.mclk  (mclk),
		.req   (mreq),
		.rdata (rdata)
	);

	// Byte k of the pushed context, PROGRAM_COUNTER_LOW first
	function automatic logic [7:0] ctx_byte(input logic [39:0] c, input logic [2:0] k);
		logic [7:0] b;
		b = c[39 - 8 * k -: 8];
		return b;
	endfunction : ctx_byte

	always_comb begin
		s_next    = s_reg;
		s_next.pv = 1'b0;
		mreq      = '{we: 1'b0, addr: s_reg.sp, wdata: 8'h00};

		unique case (flag_op)
			CSF_FL_ALU: begin
				s_next.z = (alu_result == 8'h00);
				s_next.c = alu_carry;
			end
			CSF_FL_Z_ONLY: s_next.z = (alu_result == 8'h00);
			CSF_FL_SCF:    s_next.c = 1'b1;
			CSF_FL_RCF:    s_next.c = 1'b0;
			default: ;
		endcase

		// Read data is one cycle behind its address
		if (s_reg.rd_pend) begin
			s_next.pv      = 1'b1;
			s_next.pd      = rdata;
			s_next.pi      = s_reg.rd_idx;
			s_next.rd_pend = 1'b0;
		end

		unique case (s_reg.state)
			CSF_ST_IDLE: begin
				s_next.idx = 3'h0;
				s_next.ctx = ctx_in;
				unique case (stack_op)
					CSF_SK_PUSH, CSF_SK_CALL, CSF_SK_INT: begin
						s_next.state = CSF_ST_PUSH;
						s_next.last  = (stack_op == CSF_SK_INT) ? CTX_LAST :
						               (stack_op == CSF_SK_CALL) ? CALL_LAST : 3'h0;
						if (stack_op == CSF_SK_PUSH) begin
							s_next.ctx[39 -: 8] = push_data;
						end
					end
					CSF_SK_POP, CSF_SK_RET, CSF_SK_IRET: begin
						s_next.state = CSF_ST_POP;
						s_next.last  = (stack_op == CSF_SK_IRET) ? CTX_LAST :
						               (stack_op == CSF_SK_RET) ? CALL_LAST : 3'h0;
					end
					default: ;
				endcase
			end
			CSF_ST_PUSH: begin
				// Y is not part of the context word at all
				mreq.we     = 1'b1;
				mreq.wdata  = ctx_byte(s_reg.ctx, s_reg.idx);
				s_next.sp   = s_reg.sp - 6'h01;
				s_next.idx  = s_reg.idx + 3'h1;
				if (s_reg.idx == s_reg.last) begin
					s_next.state = CSF_ST_IDLE;
				end
			end
			CSF_ST_POP: begin
				// Increment before reading; pop_index counts down to 0 (PROGRAM_COUNTER_LOW)
				s_next.sp      = s_reg.sp + 6'h01;
				mreq.addr      = s_reg.sp + 6'h01;
				s_next.rd_pend = 1'b1;
				s_next.rd_idx  = s_reg.last - s_reg.idx;
				s_next.idx     = s_reg.idx + 3'h1;
				if (s_reg.idx == s_reg.last) begin
					s_next.state = CSF_ST_IDLE;
				end
			end
			// Unused state code falls back to idle
			default: s_next.state = CSF_ST_IDLE;
		endcase

		// Direct low-byte write; fixed bits 7:6 ignore the written value
		if (sp_low_we) begin
			s_next.sp = sp_low_wdata[SP_OFS_W-1:0];
		end
		if (reload_stack_top_instr) begin
			s_next.sp = SP_RESET_VAL[SP_OFS_W-1:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s_reg       <= '0;
			s_reg.state <= CSF_ST_IDLE;
			s_reg.sp    <= SP_RESET_VAL[SP_OFS_W-1:0];
		end else begin
			s_reg <= s_next;
		end
	end

	assign stack_pointer        = {SP_FIXED_HI, s_reg.sp};
	assign pointer_low_byte     = stack_pointer[7:0];
	assign result_null_flag     = s_reg.z;
	assign overflow_borrow_flag = s_reg.c;
	assign stack_busy           = (s_reg.state != CSF_ST_IDLE);
	assign pop_valid            = s_reg.pv;
	assign pop_data             = s_reg.pd;
	assign pop_index            = s_reg.pi;

	always_comb begin
		unique case (branch_sel)
			CSF_BR_EQ: branch_taken = s_reg.z;
			CSF_BR_NE: branch_taken = !s_reg.z;
			CSF_BR_C:  branch_taken = s_reg.c;
			CSF_BR_NC: branch_taken = !s_reg.c;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	chk_zero_flag_set: assert property (
		flag_op == CSF_FL_ALU |=> result_null_flag == ($past(alu_result) == 8'h00))
		else $error("zero flag wrong");
	chk_z_only_keep: assert property (
		flag_op == CSF_FL_Z_ONLY |=> overflow_borrow_flag == $past(overflow_borrow_flag))
		else $error("zero-only op touched carry");
	chk_branch_eq: assert property (
		branch_sel == CSF_BR_EQ |-> branch_taken == result_null_flag)
		else $error("equal branch wrong");
	chk_branch_ne: assert property (
		branch_sel == CSF_BR_NE |-> branch_taken == !result_null_flag)
		else $error("not equal branch wrong");
	chk_carry_alu: assert property (
		flag_op == CSF_FL_ALU |=> overflow_borrow_flag == $past(alu_carry))
		else $error("carry wrong");
	chk_carry_force: assert property (
		flag_op == CSF_FL_SCF |=> overflow_borrow_flag)
		else $error("force carry failed");
	chk_carry_clear: assert property (
		flag_op == CSF_FL_RCF |=> !overflow_borrow_flag)
		else $error("clear carry failed");
	chk_branch_carry: assert property (
		branch_sel == CSF_BR_C |-> branch_taken == overflow_borrow_flag)
		else $error("carry branch wrong");
	chk_branch_nc: assert property (
		branch_sel == CSF_BR_NC |-> branch_taken == !overflow_borrow_flag)
		else $error("no carry branch wrong");
	chk_sp_fixed_bits: assert property (
		stack_pointer[15:6] == 10'h003)
		else $error("fixed pointer bits wrong");
	chk_push_dec: assert property (
		s_reg.state == CSF_ST_PUSH && !sp_low_we && !reload_stack_top_instr
		|=> s_reg.sp == $past(s_reg.sp) - 6'h01)
		else $error("push did not decrement");
	chk_pop_inc: assert property (
		s_reg.state == CSF_ST_POP && !sp_low_we && !reload_stack_top_instr
		|=> s_reg.sp == $past(s_reg.sp) + 6'h01)
		else $error("pop did not increment");
	chk_reload_top: assert property (
		reload_stack_top_instr |=> stack_pointer == 16'h00FF)
		else $error("reload missed top");
	chk_low_write: assert property (
		sp_low_we && !reload_stack_top_instr && sp_low_wdata[5:0] == 6'h00
		|=> pointer_low_byte == 8'hC0)
		else $error("low byte write wrong");
	chk_push_wrap: assert property (
		s_reg.state == CSF_ST_PUSH && s_reg.sp == 6'h00 && !sp_low_we &&
		!reload_stack_top_instr |=> stack_pointer == 16'h00FF)
		else $error("push wrap wrong");
	chk_pop_wrap: assert property (
		s_reg.state == CSF_ST_POP && s_reg.sp == 6'h3F && !sp_low_we &&
		!reload_stack_top_instr |=> stack_pointer == 16'h00C0)
		else $error("pop wrap wrong");
	chk_int_pcl_first: assert property (
		s_reg.state == CSF_ST_IDLE && stack_op == CSF_SK_INT
		|=> mreq.we && mreq.wdata == $past(ctx_in.program_counter_low))
		else $error("pcl not first");
	chk_push_at_sp: assert property (
		s_reg.state == CSF_ST_PUSH |-> mreq.we && mreq.addr == s_reg.sp)
		else $error("push not at pointer");
	chk_int_five: assert property (
		s_reg.state == CSF_ST_IDLE && stack_op == CSF_SK_INT && !sp_low_we &&
		!reload_stack_top_instr |=> stack_busy [*5] ##1 !stack_busy)
		else $error("interrupt push not five bytes");
	chk_ret_two: assert property (
		s_reg.state == CSF_ST_IDLE && stack_op == CSF_SK_RET
		|=> stack_busy [*2] ##1 !stack_busy)
		else $error("return pop not two bytes");
	chk_iret_cc_first: assert property (
		s_reg.state == CSF_ST_IDLE && stack_op == CSF_SK_IRET
		|-> ##3 pop_valid && pop_index == 3'h4)
		else $error("condition codes not popped first");

	// Main scenarios the bench is expected to reach
	cov_call: cover property (s_reg.state == CSF_ST_IDLE && stack_op == CSF_SK_CALL);
	cov_iret: cover property (s_reg.state == CSF_ST_IDLE && stack_op == CSF_SK_IRET);
	cov_pop_wrap: cover property (s_reg.state == CSF_ST_POP && s_reg.sp == 6'h3F);
	cov_push_wrap: cover property (s_reg.state == CSF_ST_PUSH && s_reg.sp == 6'h00);
	cov_z_only: cover property (flag_op == CSF_FL_Z_ONLY);

endmodule : csf_core

// ---- dv/tb.sv ----
// Self-checking bench for the stack pointer, stack sequencer and flags
`timescale 1ns/1ns
module tb
	import csf_pkg::*;
;
	logic          mclk = 1'b0;
	logic          sys_rst = 1'b1;
	csf_flag_op_t  flag_op = CSF_FL_NONE;
	logic [7:0]    alu_result = 8'h00;
	logic          alu_carry = 1'b0;
	csf_branch_t   branch_sel = CSF_BR_EQ;
	logic          branch_taken;
	csf_stack_op_t stack_op = CSF_SK_NONE;
	logic [7:0]    push_data = 8'h00;
	csf_ctx_t      ctx_in = 40'h11_22_33_44_55;
	logic          reload_stack_top_instr = 1'b0;
	logic          stack_busy, pop_valid;
	logic [7:0]    pop_data, pointer_low_byte;
	logic [2:0]    pop_index;
	logic          sp_low_we = 1'b0;
	logic [7:0]    sp_low_wdata = 8'h00;
	logic [15:0]   stack_pointer;
	logic          result_null_flag, overflow_borrow_flag;
	int            n_fail = 0;
	int            tests_run = 0;
	int            cycles = 0;
	logic [10:0]   pq[$];

	always #10 mclk = ~mclk;

	csf_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .flag_op(flag_op),
		.alu_result(alu_result), .alu_carry(alu_carry), .branch_sel(branch_sel),
		.branch_taken(branch_taken), .stack_op(stack_op), .push_data(push_data),
		.ctx_in(ctx_in), .reload_stack_top_instr(reload_stack_top_instr),
		.stack_busy(stack_busy), .pop_valid(pop_valid), .pop_data(pop_data),
		.pop_index(pop_index), .sp_low_we(sp_low_we), .sp_low_wdata(sp_low_wdata),
		.pointer_low_byte(pointer_low_byte), .stack_pointer(stack_pointer),
		.result_null_flag(result_null_flag), .overflow_borrow_flag(overflow_borrow_flag));

	// Popped bytes are captured as the edge sees them
	always @(posedge mclk) begin
		if (pop_valid === 1'b1)
			pq.push_back({pop_index, pop_data});
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc;
		@(posedge mclk);
		#2;
	endtask : cyc

	task automatic flag(input csf_flag_op_t op, input logic [7:0] r, input logic c);
		flag_op = op;
		alu_result = r;
		alu_carry = c;
		cyc();
		flag_op = CSF_FL_NONE;
	endtask : flag

	task automatic br(input csf_branch_t s, input logic e);
		branch_sel = s;
		#1;
		chk("branch", {15'h0000, e}, {15'h0000, branch_taken});
	endtask : br

	// Busy must rise at once and last exactly n cycles
	task automatic sop(input csf_stack_op_t op, input int n);
		int k;
		k = 0;
		stack_op = op;
		cyc();
		stack_op = CSF_SK_NONE;
		while (stack_busy !== 1'b0 && k < 20) begin
			cyc();
			k++;
		end
		chk("busy cycles", n[15:0], k[15:0]);
		repeat (3) cyc();
	endtask : sop

	task automatic pchk(input logic [2:0] i, input logic [7:0] d);
		logic [10:0] e;
		e = (pq.size() != 0) ? pq.pop_front() : 11'h7FF;
		chk("pop", {5'h00, i, d}, {5'h00, e});
	endtask : pchk

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge mclk);
		#2;
		sys_rst = 1'b0;
		chk("sp reset", 16'h00FF, stack_pointer);
		chk("flags reset", 16'h0000, {14'h0000, result_null_flag, overflow_borrow_flag});
		flag(CSF_FL_ALU, 8'h00, 1'b0);
		chk("zero set", 16'h0002, {14'h0000, result_null_flag, overflow_borrow_flag});
		br(CSF_BR_EQ, 1'b1);
		br(CSF_BR_NE, 1'b0);
		flag(CSF_FL_ALU, 8'h80, 1'b1);
		chk("carry set", 16'h0001, {14'h0000, result_null_flag, overflow_borrow_flag});
		br(CSF_BR_C, 1'b1);
		br(CSF_BR_NC, 1'b0);
		br(CSF_BR_EQ, 1'b0);
		br(CSF_BR_NE, 1'b1);
		flag(CSF_FL_RCF, 8'h00, 1'b1);
		chk("rcf", 16'h0000, {15'h0000, overflow_borrow_flag});
		flag(CSF_FL_SCF, 8'h01, 1'b0);
		chk("scf", 16'h0001, {15'h0000, overflow_borrow_flag});
		flag(CSF_FL_ALU, 8'h01, 1'b0);
		chk("shift carry", 16'h0000, {15'h0000, overflow_borrow_flag});
		flag(CSF_FL_Z_ONLY, 8'h00, 1'b1);
		chk("z only", 16'h0002, {14'h0000, result_null_flag, overflow_borrow_flag});
		$display("test flags done");
		push_data = 8'hA5;
		sop(CSF_SK_PUSH, 1);
		chk("sp push", 16'h00FE, stack_pointer);
		sop(CSF_SK_POP, 1);
		chk("sp pop", 16'h00FF, stack_pointer);
		pchk(3'h0, 8'hA5);
		sp_low_wdata = 8'h00;
		sp_low_we = 1'b1;
		cyc();
		sp_low_we = 1'b0;
		chk("sp low write", 16'h00C0, stack_pointer);
		chk("low byte", 16'h00C0, {8'h00, pointer_low_byte});
		push_data = 8'h3C;
		sop(CSF_SK_PUSH, 1);
		chk("push wrap", 16'h00FF, stack_pointer);
		sop(CSF_SK_POP, 1);
		chk("pop wrap", 16'h00C0, stack_pointer);
		pchk(3'h0, 8'h3C);
		reload_stack_top_instr = 1'b1;
		cyc();
		reload_stack_top_instr = 1'b0;
		chk("reload", 16'h00FF, stack_pointer);
		$display("test pointer done");
		sop(CSF_SK_INT, 5);
		chk("int sp", 16'h00FA, stack_pointer);
		sop(CSF_SK_IRET, 5);
		chk("iret sp", 16'h00FF, stack_pointer);
		for (int i = 4; i >= 0; i--)
			pchk(i[2:0], ctx_in[8*(4-i) +: 8]);
		sop(CSF_SK_CALL, 2);
		chk("call sp", 16'h00FD, stack_pointer);
		sop(CSF_SK_RET, 2);
		chk("ret sp", 16'h00FF, stack_pointer);
		pchk(3'h1, ctx_in.pch);
		pchk(3'h0, ctx_in.program_counter_low);
		$display("test context done");
		close_out();
	end
endmodule : tb
